// ===== hdl/dpsc_top.sv
// Purpose: power and fault status register of a quad DAC
// Assumes: serial frame decoded upstream into a one-cycle write strobe
// Notes: fault inputs are live levels from the analog monitors
//
// Function
// [RQ1] channel power bits default off, control channels
// [RQ2] host waits power-up time before loading outputs
// [RQ3] clamp off: overcurrent clears channel power bit
// [RQ4] reference power bit defaults off, enables reference
// [RQ5] overtemperature powers down all, sets thermal flag; code powers down the channels only, the reference stays on
// [RQ6] per-channel read-only overcurrent flags set by fault
// [RQ7] data layout: oc D..A, zero, thermal, ref, pu
// [RQ8] register select code 010 addresses this register
// [RQ9] clamp on: overcurrent flag clears when fault gone
// [RQ10] writes update only power bits, flags stay live
`timescale 1ns/1ps
`include "dpsc_cfg.svh"
module dpsc_top #(
  parameter int POWER_UP_CYCLES = (`DPSC_POWER_UP_TIME_NS + `DPSC_CLK_PERIOD_NS - 1) / `DPSC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_strobe,
  input wire logic [2:0] register_select,
  input wire logic [15:0] wr_data,
  input wire logic clamp_enable,
  input wire logic thermal_enable,
  input wire logic overtemp_detect,
  input wire logic [3:0] overcurrent_detect,
  output logic [15:0] rd_data,
  output logic [3:0] chan_power_on,
  output logic internal_ref_power_on,
  output logic [3:0] chan_settled
);
  if (POWER_UP_CYCLES < 1) begin : g_bad_cycles
    $error("power-up count must be at least one");
  end

  logic [3:0] pu;
  logic ref_on;
  logic sel_hit;
  logic thermal_trip;
  logic [3:0] next_pu;

  assign sel_hit = wr_strobe && (register_select == `DPSC_REG_SEL_POWER); // RQ8
  // shutdown only acts when the thermal feature is enabled
  assign thermal_trip = thermal_enable && overtemp_detect;

  always_comb begin
    next_pu = pu;
    if (sel_hit) begin
      next_pu = wr_data[`DPSC_PU_LSB +: `DPSC_NUM_CHAN]; // RQ10
    end
    // with clamp off, faults win over a same-cycle write so a shorted channel never turns on
    if (!clamp_enable) begin
      next_pu = next_pu & ~overcurrent_detect; // RQ3
    end
    if (thermal_trip) begin
      next_pu = `DPSC_PU_RESET; // RQ5
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu <= `DPSC_PU_RESET; // RQ1
    end else begin
      pu <= next_pu;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_on <= `DPSC_REF_RESET; // RQ4
    end else if (sel_hit) begin
      ref_on <= wr_data[`DPSC_REF_BIT]; // RQ4
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
      chan_power_on <= 4'h0;
      internal_ref_power_on <= 1'b0;
    end else begin
      rd_data <= 16'h0000;
      rd_data[`DPSC_PU_LSB +: `DPSC_NUM_CHAN] <= next_pu; // RQ7
      rd_data[`DPSC_REF_BIT] <= sel_hit ? wr_data[`DPSC_REF_BIT] : ref_on;
      // flags follow the live fault; host writes never reach them
      rd_data[`DPSC_THERM_BIT] <= thermal_trip; // RQ5 RQ10
      rd_data[`DPSC_ZERO_BIT] <= 1'b0;
      rd_data[`DPSC_OC_LSB +: `DPSC_NUM_CHAN] <= overcurrent_detect; // RQ6 RQ9
      chan_power_on <= next_pu; // RQ1
      internal_ref_power_on <= sel_hit ? wr_data[`DPSC_REF_BIT] : ref_on;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DPSC_NUM_CHAN; g++) begin : g_settle
      dpsc_settle #(.CYCLES(POWER_UP_CYCLES)) u_settle (
        .clk(clk),
        .rst_n(rst_n),
        .power_on(pu[g]),
        .settled(chan_settled[g])
      );
    end
  endgenerate
endmodule // dpsc_top

// ===== hdl/dpsc_cfg.svh
// Purpose: constants for the power and fault status register bank
// Assumes: 16-bit data field of the serial command word
// Notes: definitions only
`ifndef DPSC_CFG_SVH
`define DPSC_CFG_SVH
`define DPSC_REG_SEL_POWER 3'h2
`define DPSC_PU_LSB 0
`define DPSC_REF_BIT 4
`define DPSC_THERM_BIT 5
`define DPSC_ZERO_BIT 6
`define DPSC_OC_LSB 7
`define DPSC_NUM_CHAN 4
`define DPSC_PU_RESET 4'h0
`define DPSC_REF_RESET 1'h0
`define DPSC_POWER_UP_TIME_NS 10000
`define DPSC_CLK_PERIOD_NS 20
`endif

// ===== hdl/dpsc_pkg.sv
// Purpose: types for the power and fault status register bank
// Assumes: nothing beyond the cfg header
// Notes: states of the per-channel settle tracker
package dpsc_pkg;
  typedef enum logic [1:0] {
    DPSC_OFF = 2'b01,
    DPSC_ON = 2'b10
  } dpsc_chan_state_type;
endpackage

// ===== hdl/dpsc_settle.sv
// Purpose: per-channel power-up settle timer
// Assumes: clk at 50 MHz
// Notes: only a hint to the host; loads are not blocked
`timescale 1ns/1ps
`include "dpsc_cfg.svh"
module dpsc_settle #(
  parameter int CYCLES = `DPSC_POWER_UP_TIME_NS / `DPSC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_on,
  output logic settled
);
  if (CYCLES < 1) begin : g_bad_cycles
    $error("settle count must be at least one");
  end
  localparam int W = $clog2(CYCLES + 1);
  dpsc_pkg::dpsc_chan_state_type state;
  logic [W-1:0] count;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= dpsc_pkg::DPSC_OFF;
      count <= '0;
      settled <= 1'b0;
    end else begin
      unique case (state)
        dpsc_pkg::DPSC_OFF: begin
          settled <= 1'b0;
          count <= '0;
          if (power_on) begin
            state <= dpsc_pkg::DPSC_ON;
          end
        end
        dpsc_pkg::DPSC_ON: begin
          if (!power_on) begin
            state <= dpsc_pkg::DPSC_OFF;
            settled <= 1'b0;
          end else if (count == W'(CYCLES - 1)) begin
            settled <= 1'b1; // RQ2
          end else begin
            count <= count + W'(1);
          end
        end
      endcase
    end
  end
endmodule // dpsc_settle

// ===== dv/dpsc_properties.sv
// Purpose: port checker for dpsc_top
// Assumes: flags lag faults by one cycle
// Notes: bind after the module
`timescale 1ns/1ps
module dpsc_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_strobe,
  input wire logic [2:0] register_select,
  input wire logic [15:0] wr_data,
  input wire logic clamp_enable,
  input wire logic thermal_enable,
  input wire logic overtemp_detect,
  input wire logic [3:0] overcurrent_detect,
  input wire logic [15:0] rd_data,
  input wire logic [3:0] chan_power_on,
  input wire logic internal_ref_power_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr; wr_strobe && register_select == 3'h2; endsequence
  property p_wr; s_wr ##0 (clamp_enable && !thermal_enable) |=> rd_data[4:0] == $past(wr_data[4:0]); endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_oc; !clamp_enable |=> (chan_power_on & $past(overcurrent_detect)) == 4'h0; endproperty
  a_oc: assert property (p_oc) else $error("oc off");
  property p_tsd; thermal_enable && overtemp_detect |=> chan_power_on == 4'h0 && rd_data[5]; endproperty
  a_tsd: assert property (p_tsd) else $error("thermal");
  property p_ocf; 1'b1 |=> rd_data[10:7] == $past(overcurrent_detect); endproperty
  a_ocf: assert property (p_ocf) else $error("oc flag");
  property p_lay; rd_data[15:11] == 5'h0 && !rd_data[6] && rd_data[4:0] == {internal_ref_power_on, chan_power_on};
  endproperty
  a_lay: assert property (p_lay) else $error("layout");
  property p_sel; !wr_strobe || register_select != 3'h2 |=> $stable(internal_ref_power_on)
    && (chan_power_on & ~$past(chan_power_on)) == 4'h0; endproperty
  a_sel: assert property (p_sel) else $error("select");
  property p_clr; clamp_enable && $fell(overcurrent_detect[2]) |=> !rd_data[9]; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_flag; s_wr |=> rd_data[10:5] == {$past(overcurrent_detect), 1'b0,
    $past(thermal_enable) && $past(overtemp_detect)}; endproperty
  a_flag: assert property (p_flag) else $error("flags");
endmodule // dpsc_chk
bind dpsc_top dpsc_chk chk_i (.*);

// ===== dv/dpsc_host.sv
// Purpose: host model issuing decoded write frames
// Assumes: called at the falling edge
// Notes: strobe held until the next call
`timescale 1ns/1ps
module dpsc_host (
  input wire logic clk,
  output logic wr_strobe,
  output logic [2:0] register_select,
  output logic [15:0] wr_data
);
  initial {wr_strobe, register_select, wr_data} = 20'h00000;
  // no output load is issued, so the settle wait cannot be broken here
  task automatic cyc(input logic stb, input logic [2:0] sel, input logic [15:0] d);
    wr_strobe = stb;
    register_select = sel;
    wr_data = d;
    @(negedge clk);
  endtask
endmodule // dpsc_host

// ===== dv/tb.sv
// Purpose: bench for dpsc_top
// Assumes: inputs change at the falling edge
// Notes: settle count cut to 4
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst_n = 1'b0, clamp_enable = 1'b1, thermal_enable = 1'b0, overtemp_detect = 1'b0;
  logic internal_ref_power_on, wr_strobe;
  logic [2:0] register_select;
  logic [3:0] overcurrent_detect = 4'h0, chan_power_on, chan_settled;
  logic [15:0] wr_data, rd_data;
  int n_fail = 0, n_compared = 0;
  always #10 clk = ~clk;
  dpsc_host dpsc_host_i (.*);
  dpsc_top #(.POWER_UP_CYCLES(4)) dpsc_top_i (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the run needs under 60 cycles, so 100 us is a wide margin
  initial begin
    #100us;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk(rd_data, 16'h0000);
    dpsc_host_i.cyc(1'b1, 3'h2, 16'hFFFF);
    chk(rd_data, 16'h001F);
    chk({11'h000, internal_ref_power_on, chan_power_on}, 16'h001F);
    dpsc_host_i.cyc(1'b1, 3'h3, 16'h0000);
    dpsc_host_i.cyc(1'b0, 3'h2, 16'h0000);
    chk(rd_data, 16'h001F);
    repeat (4) dpsc_host_i.cyc(1'b0, 3'h2, 16'h0000);
    chk({12'h000, chan_settled}, 16'h000F);
    clamp_enable = 1'b0;
    for (int i = 0; i < 4; i++) begin
      dpsc_host_i.cyc(1'b1, 3'h2, 16'h001F);
      overcurrent_detect = 4'h1 << i;
      dpsc_host_i.cyc(1'b0, 3'h0, 16'h0000);
      chk(rd_data, 16'h001F ^ (16'h0001 << i) | (16'h0080 << i));
      overcurrent_detect = 4'h0;
      dpsc_host_i.cyc(1'b0, 3'h0, 16'h0000);
      chk(rd_data, 16'h001F ^ (16'h0001 << i));
    end
    clamp_enable = 1'b1;
    overcurrent_detect = 4'h4;
    dpsc_host_i.cyc(1'b1, 3'h2, 16'h001F);
    chk(rd_data, 16'h021F);
    overcurrent_detect = 4'h0;
    thermal_enable = 1'b1;
    overtemp_detect = 1'b1;
    dpsc_host_i.cyc(1'b1, 3'h2, 16'hFFFF);
    chk(rd_data, 16'h0030);
    thermal_enable = 1'b0;
    dpsc_host_i.cyc(1'b0, 3'h2, 16'h0000);
    chk(rd_data, 16'h0010);
    rst_n = 1'b0;
    dpsc_host_i.cyc(1'b0, 3'h2, 16'h0000);
    chk(rd_data, 16'h0000);
    complete_run();
  end
endmodule // tb
